// [verilog/actc_pkg.sv]
package actc_pkg;
	localparam int NCORE = 5;
	localparam int RES_W = 12;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam int DIV_W = 7;
	localparam int SAMPLE_TIME_COUNT_W = 10;
	localparam int WAKE_W = 4;

	localparam logic [11:0] OFF_CTRL_ONE = 12'h000;
	localparam logic [11:0] OFF_CTRL_TWO = 12'h004;
	localparam logic [11:0] OFF_CTRL_THREE = 12'h008;
	localparam logic [11:0] OFF_ANALOG_EN = 12'h00c;
	localparam logic [11:0] OFF_TRIG_MODE = 12'h010;
	localparam logic [11:0] OFF_SYS_CFG = 12'h014;
	localparam logic [11:0] OFF_STATUS = 12'h018;
	localparam logic [11:0] OFF_FEED_SEL = 12'h01c;
	localparam logic [11:0] OFF_CORE_TIME = 12'h020;
	localparam logic [11:0] OFF_CAL_CFG = 12'h040;
	localparam logic [11:0] OFF_RESULT = 12'h060;
	localparam logic [11:0] OFF_INPUT_BUF = 12'h080;

	// Control one
	localparam int CP_BIT = 12;
	localparam int ON_BIT = 15;
	localparam logic [31:0] CTRL_ONE_MASK = 32'h0000_9000;
	// Control two: divider 6:0, sample time 25:16
	localparam int SAMPLE_TIME_COUNT_LSB = 16;
	localparam logic [31:0] CTRL_TWO_MASK = 32'h03ff_007f;
	// Control three: reference 15:13, digital enables 20:16,
	// control divider 29:24, clock source 31:30
	localparam int VREF_LSB = 13;
	localparam int DIGEN_LSB = 16;
	localparam int CLKDIV_LSB = 24;
	localparam int CLKSEL_LSB = 30;
	localparam logic [31:0] CTRL_THREE_MASK = 32'hff1f_e000;
	// Analog enable control: enables 4:0, wake-up count 27:24
	localparam int WAKE_LSB = 24;
	localparam logic [31:0] ANALOG_EN_MASK = 32'h0f00_001f;
	localparam logic [31:0] ANALOG_EN_RST = 32'h0000_0000;
	// Trigger mode
	localparam int ALT_LSB = 16;
	localparam int PRESYNC_LSB = 8;
	localparam int SSAMP_LSB = 0;
	localparam logic [31:0] TRIG_MODE_MASK = 32'h03ff_1f1f;
	localparam logic [1:0] ALT_CODE_PRIMARY = 2'h0;
	localparam logic [1:0] ALT_CODE_ALTERNATE = 2'h1;
	// System config
	localparam int SYS_CP_BIT = 7;
	localparam logic [31:0] SYS_CFG_MASK = 32'h0000_0080;
	// Per-core time: divider 6:0, resolution 9:8, sample time 25:16
	localparam int RES_LSB = 8;
	localparam logic [31:0] CORE_TIME_MASK = 32'h03ff_037f;
	// Status: ready 4:0, fifo not empty 12:8, fifo full 20:16
	localparam int ST_NEMPTY_LSB = 8;
	localparam int ST_FULL_LSB = 16;
endpackage : actc_pkg

// [verilog/actc_core_clk.sv]
`timescale 1ns/10ps
// Divides the control clock into one core's clock enable.
module actc_core_clk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [actc_pkg::DIV_W-1:0] div,
	input wire logic [actc_pkg::WAKE_W-1:0] wake_cnt,
	output logic tick,
	output logic ready
);
	logic [actc_pkg::DIV_W-1:0] cnt_r;
	logic [actc_pkg::WAKE_W-1:0] wake_r;

	// A divider of zero is treated as one: a tick every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r + 7'h01 >= div) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 7'h01;
			tick <= 1'b0;
		end
	end

	// Core counts as warmed up after one more than the wake-up number of its ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_r <= '0;
			ready <= 1'b0;
		end else if (!run) begin
			wake_r <= '0;
			ready <= 1'b0;
		end else if (tick && !ready) begin
			if (wake_r >= wake_cnt)
				ready <= 1'b1;
			else
				wake_r <= wake_r + 4'h1;
		end
	end
endmodule : actc_core_clk

// [verilog/actc_result_fifo.sv]
`timescale 1ns/10ps
// Result FIFO of one dedicated core; a result arriving when full is lost.
module actc_result_fifo (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push,
	input wire logic [actc_pkg::RES_W-1:0] wdata,
	input wire logic pop,
	output logic [actc_pkg::RES_W-1:0] rdata,
	output logic empty,
	output logic full
);
	logic [actc_pkg::RES_W-1:0] mem [actc_pkg::FIFO_DEPTH];
	logic [actc_pkg::FIFO_AW:0] wp_r;
	logic [actc_pkg::FIFO_AW:0] rp_r;

	assign empty = (wp_r == rp_r);
	assign full = (wp_r[actc_pkg::FIFO_AW] != rp_r[actc_pkg::FIFO_AW]) &&
		(wp_r[actc_pkg::FIFO_AW-1:0] == rp_r[actc_pkg::FIFO_AW-1:0]);
	assign rdata = mem[rp_r[actc_pkg::FIFO_AW-1:0]];

	always_ff @(posedge pclk) begin
		if (push && !full)
			mem[wp_r[actc_pkg::FIFO_AW-1:0]] <= wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push && !full)
				wp_r <= wp_r + 5'h01;
			if (pop && !empty)
				rp_r <= rp_r + 5'h01;
		end
	end
endmodule : actc_result_fifo

// [verilog/actc_top.sv]
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
// Dedicated-core control: registers, core clocks, input select,
// trigger routing and result capture.
module actc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [actc_pkg::NCORE-1:0] trig_in,
	input wire logic [actc_pkg::NCORE-1:0] conv_done,
	input wire logic [actc_pkg::NCORE*actc_pkg::RES_W-1:0] conv_data,
	output logic module_on,
	output logic converter_charge_pump_enable,
	output logic system_analog_charge_pump_enable,
	output logic [actc_pkg::NCORE-1:0] core_clk_en,
	output logic [actc_pkg::NCORE-1:0] core_bias_en,
	output logic [actc_pkg::NCORE-1:0] core_ready,
	output logic [actc_pkg::NCORE-1:0] core_alt_input,
	output logic [actc_pkg::NCORE-1:0] core_sampling_mode,
	output logic [actc_pkg::NCORE-1:0] core_trigger,
	output logic [actc_pkg::NCORE*2-1:0] core_resolution,
	output logic [actc_pkg::NCORE*actc_pkg::SAMPLE_TIME_COUNT_W-1:0] core_sample_time,
	output logic [actc_pkg::NCORE-1:0] feed_valid,
	output logic [actc_pkg::NCORE*actc_pkg::RES_W-1:0] feed_data
);
	localparam int N = actc_pkg::NCORE;
	localparam int RW = actc_pkg::RES_W;

	logic [31:0] ctrl_one_r;
	logic [31:0] ctrl_two_r;
	logic [31:0] ctrl_three_r;
	logic [31:0] analog_en_r;
	logic [31:0] dedicated_core_trigger_mode;
	logic [31:0] sys_cfg_r;
	logic [N-1:0] feed_sel_r;
	logic [31:0] core_time_r [N];
	logic [31:0] core_calibration_config [N];
	// Result buffers: one per input, primary at 2*i, alternate at 2*i+1
	logic [RW-1:0] input_buf_r [2*N];

	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [31:0] rd_mux;
	logic [N-1:0] fifo_pop;
	logic [N-1:0] fifo_empty;
	logic [N-1:0] fifo_full;
	logic [RW-1:0] fifo_rdata [N];
	logic [N-1:0] core_tick;
	logic [N-1:0] trig_pend_r;
	logic [N-1:0] core_analog_enable;
	logic [N-1:0] core_digital_enable;
	logic [N-1:0] core_trigger_presync_enable;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	// Unmapped addresses answer with an error and change nothing
	assign pslverr = psel && penable && !addr_hit;

	assign module_on = ctrl_one_r[actc_pkg::ON_BIT];
	assign converter_charge_pump_enable = ctrl_one_r[actc_pkg::CP_BIT];
	assign system_analog_charge_pump_enable =
		sys_cfg_r[actc_pkg::SYS_CP_BIT];
	// Enables fan out per core from the shared registers
	assign core_analog_enable = analog_en_r[N-1:0];
	assign core_digital_enable =
		ctrl_three_r[actc_pkg::DIGEN_LSB +: N];
	assign core_trigger_presync_enable =
		dedicated_core_trigger_mode[actc_pkg::PRESYNC_LSB +: N];
	assign core_sampling_mode =
		dedicated_core_trigger_mode[actc_pkg::SSAMP_LSB +: N];

	// Address decode and read mux
	// Per-core and per-input offsets are matched in loops over one base
	always_comb begin
		addr_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
		actc_pkg::OFF_CTRL_ONE: rd_mux = ctrl_one_r;
		actc_pkg::OFF_CTRL_TWO: rd_mux = ctrl_two_r;
		actc_pkg::OFF_CTRL_THREE: rd_mux = ctrl_three_r;
		actc_pkg::OFF_ANALOG_EN: rd_mux = analog_en_r;
		actc_pkg::OFF_TRIG_MODE: rd_mux = dedicated_core_trigger_mode;
		actc_pkg::OFF_SYS_CFG: rd_mux = sys_cfg_r;
		actc_pkg::OFF_FEED_SEL: rd_mux = {27'h0, feed_sel_r};
		actc_pkg::OFF_STATUS: begin
			rd_mux[N-1:0] = core_ready;
			rd_mux[actc_pkg::ST_NEMPTY_LSB +: N] = ~fifo_empty;
			rd_mux[actc_pkg::ST_FULL_LSB +: N] = fifo_full;
		end
		default: begin
			addr_hit = 1'b0;
			for (int i = 0; i < N; i++) begin
				if (paddr == actc_pkg::OFF_CORE_TIME + 12'(4 * i)) begin
					addr_hit = 1'b1;
					rd_mux = core_time_r[i];
				end
				if (paddr == actc_pkg::OFF_CAL_CFG + 12'(4 * i)) begin
					addr_hit = 1'b1;
					rd_mux = core_calibration_config[i];
				end
				if (paddr == actc_pkg::OFF_RESULT + 12'(4 * i)) begin
					addr_hit = 1'b1;
					// An empty FIFO reads as zero, never as unwritten memory
					if (!fifo_empty[i])
						rd_mux = {20'h0, fifo_rdata[i]};
				end
			end
			for (int j = 0; j < 2 * N; j++) begin
				if (paddr == actc_pkg::OFF_INPUT_BUF + 12'(4 * j)) begin
					addr_hit = 1'b1;
					rd_mux = {20'h0, input_buf_r[j]};
				end
			end
		end
		endcase
	end

	assign prdata = rd_mux;

	// Shared control registers; writes masked so unimplemented bits stay 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_r <= 32'h0000_0000;
			ctrl_two_r <= 32'h0000_0000;
			ctrl_three_r <= 32'h0000_0000;
			analog_en_r <= actc_pkg::ANALOG_EN_RST;
			sys_cfg_r <= 32'h0000_0000;
		end else if (wr_en) begin
			case (paddr)
			actc_pkg::OFF_CTRL_ONE:
				ctrl_one_r <= pwdata & actc_pkg::CTRL_ONE_MASK;
			actc_pkg::OFF_CTRL_TWO:
				ctrl_two_r <= pwdata & actc_pkg::CTRL_TWO_MASK;
			actc_pkg::OFF_CTRL_THREE:
				ctrl_three_r <= pwdata & actc_pkg::CTRL_THREE_MASK;
			actc_pkg::OFF_ANALOG_EN:
				analog_en_r <= pwdata & actc_pkg::ANALOG_EN_MASK;
			actc_pkg::OFF_SYS_CFG:
				sys_cfg_r <= pwdata & actc_pkg::SYS_CFG_MASK;
			// Status, result and buffer offsets are read-only here
			default: begin
			end
			endcase
		end
	end

	// Feed select decides which cores pass results on to filter and comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			feed_sel_r <= '0;
		else if (wr_en && paddr == actc_pkg::OFF_FEED_SEL)
			feed_sel_r <= pwdata[N-1:0];
	end

	// Trigger-mode register
	// Reserved input codes are kept so software reads back what it wrote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dedicated_core_trigger_mode <= 32'h0000_0000;
		else if (wr_en && paddr == actc_pkg::OFF_TRIG_MODE)
			dedicated_core_trigger_mode <=
				pwdata & actc_pkg::TRIG_MODE_MASK;
	end

	// Per-core shared control: clocks, time settings, triggers, results
	for (genvar g = 0; g < N; g++) begin : g_core
		logic [1:0] alt_code;
		logic use_alt;
		logic run;

		assign alt_code = dedicated_core_trigger_mode[
			actc_pkg::ALT_LSB + 2 * g +: 2];
		// Reserved codes fall back to the primary input
		assign use_alt = (alt_code == actc_pkg::ALT_CODE_ALTERNATE);
		// Clock runs from the analog enable alone so the core can warm up
		// before the module is switched on
		assign run = core_analog_enable[g];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				core_time_r[g] <= 32'h0000_0000;
			else if (wr_en &&
				paddr == actc_pkg::OFF_CORE_TIME + 12'(4 * g))
				core_time_r[g] <= pwdata & actc_pkg::CORE_TIME_MASK;
		end

		// Calibration words are plain storage for the analog side
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				core_calibration_config[g] <= 32'h0000_0000;
			else if (wr_en &&
				paddr == actc_pkg::OFF_CAL_CFG + 12'(4 * g))
				core_calibration_config[g] <= pwdata;
		end

		// One wake-up count serves all cores
		actc_core_clk actc_core_clk_inst (
			.pclk(pclk),
			.presetn(presetn),
			.run(run),
			.div(core_time_r[g][actc_pkg::DIV_W-1:0]),
			.wake_cnt(analog_en_r[actc_pkg::WAKE_LSB +: actc_pkg::WAKE_W]),
			.tick(core_tick[g]),
			.ready(core_ready[g])
		);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				core_clk_en[g] <= 1'b0;
				core_bias_en[g] <= 1'b0;
			end else begin
				core_clk_en[g] <= core_tick[g];
				core_bias_en[g] <= run;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				core_alt_input[g] <= 1'b0;
			else
				core_alt_input[g] <= use_alt;
		end

		// Time settings are copied out so the core sees registered values
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				core_resolution[2 * g +: 2] <= 2'h0;
				core_sample_time[actc_pkg::SAMPLE_TIME_COUNT_W * g +: actc_pkg::SAMPLE_TIME_COUNT_W]
					<= '0;
			end else begin
				core_resolution[2 * g +: 2] <=
					core_time_r[g][actc_pkg::RES_LSB +: 2];
				core_sample_time[actc_pkg::SAMPLE_TIME_COUNT_W * g +: actc_pkg::SAMPLE_TIME_COUNT_W]
					<= core_time_r[g][actc_pkg::SAMPLE_TIME_COUNT_LSB +:
					actc_pkg::SAMPLE_TIME_COUNT_W];
			end
		end

		// Presync: a trigger is held and released on the core's next tick,
		// which costs up to one core period of latency
		// Switching the module or the core's digital side off drops it
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				trig_pend_r[g] <= 1'b0;
				core_trigger[g] <= 1'b0;
			end else if (!(module_on && core_digital_enable[g])) begin
				trig_pend_r[g] <= 1'b0;
				core_trigger[g] <= 1'b0;
			end else if (core_trigger_presync_enable[g]) begin
				core_trigger[g] <= core_tick[g] && (trig_pend_r[g] || trig_in[g]);
				trig_pend_r[g] <= !core_tick[g] && (trig_pend_r[g] || trig_in[g]);
			end else begin
				core_trigger[g] <= trig_in[g];
				trig_pend_r[g] <= 1'b0;
			end
		end

		// Result goes to the buffer of whichever input was sampled
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				input_buf_r[2 * g] <= '0;
				input_buf_r[2 * g + 1] <= '0;
			end else if (conv_done[g]) begin
				if (use_alt)
					input_buf_r[2 * g + 1] <= conv_data[RW * g +: RW];
				else
					input_buf_r[2 * g] <= conv_data[RW * g +: RW];
			end
		end

		// Feed to filter and comparator only for selected cores
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				feed_valid[g] <= 1'b0;
				feed_data[RW * g +: RW] <= '0;
			end else begin
				feed_valid[g] <= conv_done[g] && feed_sel_r[g];
				if (conv_done[g] && feed_sel_r[g])
					feed_data[RW * g +: RW] <= conv_data[RW * g +: RW];
			end
		end

		assign fifo_pop[g] = rd_en &&
			(paddr == actc_pkg::OFF_RESULT + 12'(4 * g));

		// Every finished result is queued unless the FIFO is full, whichever input it came from
		actc_result_fifo actc_result_fifo_inst (
			.pclk(pclk),
			.presetn(presetn),
			.push(conv_done[g]),
			.wdata(conv_data[RW * g +: RW]),
			.pop(fifo_pop[g]),
			.rdata(fifo_rdata[g]),
			.empty(fifo_empty[g]),
			.full(fifo_full[g])
		);
	end
endmodule : actc_top

// [testbench/actc_top_monitor.sv]
`timescale 1ns/10ps
module actc_top_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [actc_pkg::NCORE-1:0] conv_done,
	input wire logic module_on,
	input wire logic converter_charge_pump_enable,
	input wire logic system_analog_charge_pump_enable,
	input wire logic [actc_pkg::NCORE-1:0] core_clk_en,
	input wire logic [actc_pkg::NCORE-1:0] core_bias_en,
	input wire logic [actc_pkg::NCORE-1:0] core_ready,
	input wire logic [actc_pkg::NCORE-1:0] core_alt_input,
	input wire logic [actc_pkg::NCORE-1:0] core_sampling_mode,
	input wire logic [actc_pkg::NCORE-1:0] core_trigger,
	input wire logic [actc_pkg::NCORE-1:0] feed_valid
);
	logic wr, rd, wr_tm, wr_an;
	logic [9:0] alt_r;
	logic [4:0] en_r, alt_exp;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign wr_tm = wr & (paddr == actc_pkg::OFF_TRIG_MODE);
	assign wr_an = wr & (paddr == actc_pkg::OFF_ANALOG_EN);
	// Shadow of the last written fields, so outputs can lag a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_r <= 10'h000;
			en_r <= 5'h00;
		end else begin
			if (wr_tm)
				alt_r <= pwdata[25:16];
			if (wr_an)
				en_r <= pwdata[4:0];
		end
	end
	// Reserved codes must act as the primary input
	always_comb begin
		for (int i = 0; i < 5; i++)
			alt_exp[i] = alt_r[2*i +: 2] == 2'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RESERVED_ZERO: assert property (
		rd && paddr == actc_pkg::OFF_TRIG_MODE |-> !pslverr &&
		(prdata & ~actc_pkg::TRIG_MODE_MASK) == 32'h0)
		else $error("reserved trigger mode bits not zero");
	AST_ALT_CORE4: assert property (
		wr_tm |-> ##[1:2] core_alt_input[4] == alt_exp[4])
		else $error("core 4 input select wrong");
	AST_ALT_CORES_LOW: assert property (
		wr_tm |-> ##[1:2] core_alt_input[3:0] == alt_exp[3:0])
		else $error("core 3 to 0 input select wrong");
	AST_SAMPLING_MODE: assert property (
		wr_tm |=> core_sampling_mode == $past(pwdata[4:0]))
		else $error("sampling mode does not follow write");
	AST_CONV_PUMP: assert property (
		wr && paddr == actc_pkg::OFF_CTRL_ONE |=>
		converter_charge_pump_enable == $past(pwdata[12]))
		else $error("converter pump enable wrong");
	AST_MODULE_ON: assert property (
		wr && paddr == actc_pkg::OFF_CTRL_ONE |=>
		module_on == $past(pwdata[15]))
		else $error("module on wrong");
	AST_SYS_PUMP: assert property (
		wr && paddr == actc_pkg::OFF_SYS_CFG |=>
		system_analog_charge_pump_enable == $past(pwdata[7]))
		else $error("system pump enable wrong");
	AST_BIAS_FOLLOWS: assert property (
		wr_an |-> ##[1:2] core_bias_en == en_r)
		else $error("bias enable does not follow write");
	AST_CLK_NEEDS_BIAS: assert property (
		(core_clk_en & ~core_bias_en & ~$past(core_bias_en)) == 5'h00)
		else $error("core clock runs without analog enable");
	AST_FEED_AFTER_DONE: assert property (
		(feed_valid & ~$past(conv_done)) == 5'h00)
		else $error("feed without finished conversion");
	AST_TRIG_NEEDS_ON: assert property (
		|core_trigger |-> $past(module_on))
		else $error("trigger while module off");
	cover property (|feed_valid);
	cover property (|core_trigger);
	cover property (pslverr && rd);
	cover property (&core_ready);
endmodule : actc_top_monitor
bind actc_top actc_top_monitor actc_top_monitor_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .conv_done, .module_on,
	.converter_charge_pump_enable, .system_analog_charge_pump_enable,
	.core_clk_en, .core_bias_en, .core_ready, .core_alt_input,
	.core_sampling_mode, .core_trigger, .feed_valid);

// [testbench/actc_top_tb.sv]
`timescale 1ns/10ps
module actc_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, module_on, err;
	logic converter_charge_pump_enable, system_analog_charge_pump_enable;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h74a477e0;
	logic [4:0] trig_in = 5'h00, conv_done = 5'h00, core_clk_en;
	logic [4:0] core_bias_en, core_ready, core_alt_input, feed_valid;
	logic [4:0] core_sampling_mode, core_trigger;
	logic [59:0] conv_data = 60'h0, feed_data;
	logic [9:0] core_resolution;
	logic [49:0] core_sample_time;
	int n_errors = 0, comparisons = 0, cycles = 0;
	actc_top actc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .trig_in, .conv_done,
		.conv_data, .module_on, .converter_charge_pump_enable,
		.system_analog_charge_pump_enable, .core_clk_en, .core_bias_en,
		.core_ready, .core_alt_input, .core_sampling_mode, .core_trigger,
		.core_resolution, .core_sample_time, .feed_valid, .feed_data);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	task check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function logic [4:0] alt_exp(input logic [31:0] w);
		for (int i = 0; i < 5; i++)
			alt_exp[i] = w[16+2*i +: 2] == 2'h1;
	endfunction : alt_exp
	// Returns at a falling edge so outputs are settled for checks
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb
	task fire;
		@(posedge pclk);
		trig_in <= 5'h1f;
		@(posedge pclk);
		trig_in <= 5'h00;
		@(negedge pclk);
	endtask : fire
	// Triggers may only appear with or just after their core's tick
	task watch(output logic [4:0] got, bad);
		logic [4:0] prev;
		got = 5'h00;
		bad = 5'h00;
		prev = 5'h00;
		repeat (16) begin
			got |= core_trigger;
			bad |= core_trigger & ~(core_clk_en | prev);
			prev = core_clk_en;
			@(negedge pclk);
		end
	endtask : watch
	initial begin
		logic [31:0] corner [4];
		logic [31:0] w;
		logic [11:0] q [$];
		logic [4:0] got, bad;
		int n;
		corner = '{32'hffffffff, 32'h0, 32'h01550000, 32'h02aa0000};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, actc_pkg::OFF_TRIG_MODE, 32'h0);
		check("trig mode reset", rd, 32'h0);
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			w = (i < 4) ? corner[i] : seed;
			apb(1, actc_pkg::OFF_TRIG_MODE, w);
			apb(0, actc_pkg::OFF_TRIG_MODE, 32'h0);
			check("trig mode", rd, w & actc_pkg::TRIG_MODE_MASK);
			check("alt 4", core_alt_input[4], alt_exp(w) >> 4);
			check("alt 3-0", core_alt_input[3:0], alt_exp(w) & 5'hf);
			check("sampling", core_sampling_mode, w[4:0]);
		end
		apb(0, 12'hffc, 32'h0);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		apb(1, actc_pkg::OFF_CTRL_ONE, 32'h00001000);
		apb(1, actc_pkg::OFF_SYS_CFG, 32'h00000080);
		check("pumps", {module_on, converter_charge_pump_enable,
			system_analog_charge_pump_enable}, 3'h3);
		apb(1, actc_pkg::OFF_CTRL_TWO, 32'h00200004);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			apb(1, actc_pkg::OFF_CAL_CFG + 12'(4*i), seed);
			w = (seed & actc_pkg::CORE_TIME_MASK & ~32'h7f) | (8 + i);
			apb(1, actc_pkg::OFF_CORE_TIME + 12'(4*i), w);
			apb(0, actc_pkg::OFF_CAL_CFG + 12'(4*i), 32'h0);
			check("calibration", rd, seed);
			check("resolution", core_resolution[2*i +: 2], w[9:8]);
			check("sample_time_count", core_sample_time[10*i +: 10], w[25:16]);
		end
		apb(1, actc_pkg::OFF_ANALOG_EN, 32'h0a000000);
		apb(1, actc_pkg::OFF_CTRL_THREE, 32'h41002000);
		check("bias off", core_bias_en, 5'h00);
		apb(1, actc_pkg::OFF_ANALOG_EN, 32'h0a00001f);
		@(negedge pclk);
		check("bias on", core_bias_en, 5'h1f);
		n = 0;
		while (core_ready !== 5'h1f && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		check("ready", core_ready, 5'h1f);
		for (int i = 0; i < 5; i++) begin
			while (core_clk_en[i] !== 1'b1)
				@(negedge pclk);
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (core_clk_en[i] !== 1'b1);
			check("core period", n, 8 + i);
		end
		apb(1, actc_pkg::OFF_CTRL_THREE, 32'h411f2000);
		apb(1, actc_pkg::OFF_CTRL_ONE, 32'h00008000);
		apb(1, actc_pkg::OFF_TRIG_MODE, 32'h0);
		fire();
		check("unsync trigger", core_trigger, 5'h1f);
		apb(1, actc_pkg::OFF_TRIG_MODE, 32'h00001f00);
		fire();
		watch(got, bad);
		check("presync trigger", {got, bad}, 10'h3e0);
		apb(1, actc_pkg::OFF_CTRL_ONE, 32'h0);
		fire();
		watch(got, bad);
		check("trigger when off", got, 5'h00);
		apb(1, actc_pkg::OFF_FEED_SEL, 32'h1);
		for (int k = 0; k < 17; k++) begin
			seed = lfsr(seed);
			@(posedge pclk);
			conv_done <= 5'h01;
			conv_data <= {48'h0, seed[11:0]};
			@(posedge pclk);
			conv_done <= 5'h00;
			@(negedge pclk);
			check("feed", {feed_valid, feed_data[11:0]}, {5'h1, seed[11:0]});
			if (k < 16)
				q.push_back(seed[11:0]);
		end
		apb(0, actc_pkg::OFF_INPUT_BUF, 32'h0);
		check("input buffer", rd[11:0], seed[11:0]);
		apb(1, actc_pkg::OFF_TRIG_MODE, 32'h00010000);
		seed = lfsr(seed);
		@(posedge pclk);
		conv_done <= 5'h01;
		conv_data <= {48'h0, seed[11:0]};
		@(posedge pclk);
		conv_done <= 5'h00;
		apb(0, actc_pkg::OFF_INPUT_BUF + 12'h004, 32'h0);
		check("alternate buffer", rd[11:0], seed[11:0]);
		apb(0, actc_pkg::OFF_STATUS, 32'h0);
		check("fifo full", {rd[16], rd[8]}, 2'h3);
		for (int k = 0; k < 16; k++) begin
			apb(0, actc_pkg::OFF_RESULT, 32'h0);
			check("fifo data", rd[11:0], q[k]);
		end
		apb(0, actc_pkg::OFF_STATUS, 32'h0);
		check("fifo empty", {rd[16], rd[8]}, 2'h0);
		wrap_up();
	end
endmodule : actc_top_tb
